//--- design/step_seq_params.svh
// constants of the closed loop step sequencer
`ifndef STEP_SEQ_PARAMS_SVH
`define STEP_SEQ_PARAMS_SVH
`define SEQ_STATES        4'd10
`define SEQ_LAST          4'd9
`define SEQ_ZERO          4'd0
// 1.8 deg in 0.72 deg states is 2.5, so a magnitude of three reaches it
`define DEV_THRESH        16'sd3
`define FILT_SETTINGS     5'd16
`define CLK_MHZ           40
`define IDLE_TIME_MS      100
`define IDLE_CYCLES       (`IDLE_TIME_MS * `CLK_MHZ * 1000)
`endif

//--- design/step_seq_pkg.sv
// types shared by the step sequencer modules
package step_seq_pkg;
   typedef enum logic {
      MODE_OPEN,
      MODE_CLOSED
   } loop_mode_t;
   typedef enum logic {
      IN_ONE_PULSE,
      IN_TWO_PULSE
   } pulse_mode_t;
endpackage

//--- design/phase_if.sv
// carrier between the sequencer and its modulo-ten phase counter
`timescale 1ns/1ps
interface phase_if;
   logic       step;
   logic       dir_up;
   logic [3:0] phase;
   modport ctrl (output step, output dir_up, input phase);
   modport cnt  (input step, input dir_up, output phase);
endinterface

//--- design/phase_counter.sv
// ten-state excitation phase counter
`timescale 1ns/1ps
`include "step_seq_params.svh"
module phase_counter (
   input  wire logic core_clk_i,
   input  wire logic rst_b_i,
   phase_if.cnt      pif
);
   logic [3:0] phase_q;
   assign pif.phase = phase_q;

   // wrap both ways between nine and zero
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         phase_q <= `SEQ_ZERO;
      end else if (pif.step) begin
         if (pif.dir_up) begin
            phase_q <= (phase_q == `SEQ_LAST) ? `SEQ_ZERO : phase_q + 4'd1; // R13
         end else begin
            phase_q <= (phase_q == `SEQ_ZERO) ? `SEQ_LAST : phase_q - 4'd1; // R13
         end
      end
   end
endmodule

//--- design/closed_loop_step_sequencer.sv
// step sequencer with deviation counter and open/closed loop selection
// Behaviour
// R1: signed deviation equals commanded steps minus sensed rotor steps.
// R2: deviation below 1.8 degrees runs open loop from commanded sequence.
// R3: deviation at or above 1.8 degrees switches to closed loop.
// R4: closed loop excites from rotor position counter for maximum torque.
// R5: velocity filter with sixteen settings smooths start and stop.
// R6: timing output high whenever sequence sits at state zero.
// R7: reset enters state zero; each accepted pulse advances one state.
// R8: one full ten-state cycle per 7.2 degrees of commanded motion.
// R9: controller stops pulses once home detection is confirmed.
// R10: controller gates its stop with timing output for repeatable home.
// R11: one-pulse (step plus direction) and two-pulse (cw/ccw) input modes.
// R12: about 0.1 s without pulses lowers standstill current.
// R13: sequence is a modulo-ten counter, up or down, wrapping 9 and 0.
`timescale 1ns/1ps
`include "step_seq_params.svh"
module closed_loop_step_sequencer
   import step_seq_pkg::*;
#(
   parameter int DEV_W       = 16,
   parameter int IDLE_CYCLES = `IDLE_CYCLES
) (
   input  wire logic        core_clk_i,
   input  wire logic        rst_b_i,
   input  wire logic        pulse_mode_i,
   input  wire logic        step_cw_i,
   input  wire logic        ccw_dir_i,
   input  wire logic        rotor_step_i,
   input  wire logic        rotor_dir_cw_i,
   input  wire logic [3:0]  filter_sel_i,
   output logic [3:0]       excite_phase_o,
   output logic             excitation_phase_zero_output,
   output logic             closed_loop_o,
   output logic             current_cutback_o,
   output logic signed [DEV_W-1:0] deviation_o
);
   // elaboration guard: narrower deviation counts wrap before the threshold
   // logic can see them, and the silence counter needs at least two states
   if (DEV_W < 8 || IDLE_CYCLES < 2) begin : g_param_check
      $error("unsupported parameters");
   end

   // unit deviation step, threshold at the counter's width, silence limit
   localparam logic signed [DEV_W-1:0] DEV_ONE   = DEV_W'(1);
   localparam logic signed [DEV_W-1:0] DEV_LIMIT = DEV_W'(`DEV_THRESH);
   localparam logic [31:0]             IDLE_LAST = 32'(IDLE_CYCLES - 1);

   logic              cw_prev_q;
   logic              ccw_prev_q;
   logic              cmd_step;
   logic              cmd_up;
   logic              acc_q;
   logic              acc_up_q;
   logic [4:0]        div_q;
   logic signed [DEV_W-1:0] dev_q;
   logic [3:0]        rotor_ph_q;
   logic [31:0]       idle_q;
   logic signed [DEV_W-1:0] cmd_delta;
   logic signed [DEV_W-1:0] rot_delta;
   logic              dev_big;
   loop_mode_t        mode_q;
   pulse_mode_t       pmode;
   phase_if           pif ();

   assign pmode = pulse_mode_t'(pulse_mode_i);

   // edge detect of pulse inputs; reset value is the idle low level of both
   // pins, so no false edge follows reset
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         cw_prev_q  <= 1'b0;
         ccw_prev_q <= 1'b0;
      end else begin
         cw_prev_q  <= step_cw_i;
         ccw_prev_q <= ccw_dir_i;
      end
   end

   // decode commanded step from either input mode
   always_comb begin
      cmd_step = 1'b0;
      cmd_up   = 1'b1;
      case (pmode)
         IN_ONE_PULSE: begin
            cmd_step = step_cw_i & ~cw_prev_q; // R11
            cmd_up   = ~ccw_dir_i;
         end
         IN_TWO_PULSE: begin
            cmd_step = (step_cw_i & ~cw_prev_q) ^ (ccw_dir_i & ~ccw_prev_q); // R11
            cmd_up   = step_cw_i & ~cw_prev_q;
         end
         default: begin
            cmd_step = 1'b0;
            cmd_up   = 1'b1;
         end
      endcase
   end

   // velocity filter: hold accepted step for 0..15 extra cycles (delay, not
   // lost pulses); a new pulse during the hold releases the pending one at
   // once, so a burst faster than the filter still lands every step
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         acc_q    <= 1'b0;
         acc_up_q <= 1'b1;
         div_q    <= 5'd0;
      end else if (cmd_step) begin
         acc_q    <= 1'b1;
         acc_up_q <= cmd_up;
         div_q    <= {1'b0, filter_sel_i}; // R5
      end else if (acc_q && div_q != 5'd0) begin
         div_q <= div_q - 5'd1; // R5
      end else begin
         acc_q <= 1'b0;
      end
   end

   // pending step goes out when its hold expires or when the next one arrives
   assign pif.step   = acc_q & ((div_q == 5'd0) | cmd_step); // R7
   assign pif.dir_up = acc_up_q;

   // command sequence counter; only filtered steps ever reach it
   phase_counter u_phase (
      .core_clk_i (core_clk_i),
      .rst_b_i    (rst_b_i),
      .pif        (pif)
   );

   // signed steps contributed this cycle by the command and by the sensor
   always_comb begin
      cmd_delta = '0;
      rot_delta = '0;
      if (pif.step) begin
         cmd_delta = pif.dir_up ? DEV_ONE : -DEV_ONE; // R1
      end
      if (rotor_step_i) begin
         rot_delta = rotor_dir_cw_i ? DEV_ONE : -DEV_ONE; // R1
      end
   end

   // deviation count: command minus rotor; wraps silently if the motor is
   // held off for more than half the counter range, so size DEV_W generously
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         dev_q <= '0;
      end else begin
         dev_q <= dev_q + cmd_delta - rot_delta; // R1
      end
   end

   // rotor position counter, modulo ten like the command
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         rotor_ph_q <= `SEQ_ZERO;
      end else if (rotor_step_i) begin
         if (rotor_dir_cw_i) begin
            rotor_ph_q <= (rotor_ph_q == `SEQ_LAST) ? `SEQ_ZERO : rotor_ph_q + 4'd1;
         end else begin
            rotor_ph_q <= (rotor_ph_q == `SEQ_ZERO) ? `SEQ_LAST : rotor_ph_q - 4'd1;
         end
      end
   end

   // magnitude test on both signs; reaching the threshold already counts
   assign dev_big = (dev_q >= DEV_LIMIT) || (dev_q <= -DEV_LIMIT); // R3

   // mode from deviation magnitude; sensor and command both count 0.72 deg
   // states, so the two counts can be compared directly
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         mode_q <= MODE_OPEN;
      end else if (dev_big) begin
         mode_q <= MODE_CLOSED; // R3
      end else begin
         mode_q <= MODE_OPEN; // R2
      end
   end

   // excitation source and timing output, all registered
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         excite_phase_o               <= `SEQ_ZERO;
         excitation_phase_zero_output <= 1'b1;
         closed_loop_o                <= 1'b0;
         deviation_o                  <= '0;
      end else begin
         // closed loop takes the rotor counter's state directly; assumes the
         // sensor states are aligned with the winding states at reset
         excite_phase_o <= (mode_q == MODE_CLOSED) ? rotor_ph_q : pif.phase; // R4 R2
         // ten states of 0.72 deg = 7.2 deg per cycle
         excitation_phase_zero_output <= (pif.phase == `SEQ_ZERO); // R6 R8
         closed_loop_o <= (mode_q == MODE_CLOSED);
         deviation_o   <= dev_q;
      end
   end

   // pulse silence counter; saturates so the cutback holds until a pulse
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         idle_q <= 32'd0;
      end else if (cmd_step) begin
         idle_q <= 32'd0;
      end else if (idle_q < IDLE_LAST) begin
         idle_q <= idle_q + 32'd1;
      end
   end

   // standstill current cutback after pulse silence; a fresh pulse wins over
   // the timeout in the same cycle, since the motor is about to move
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         current_cutback_o <= 1'b0;
      end else if (cmd_step) begin
         current_cutback_o <= 1'b0; // R12
      end else if (idle_q >= IDLE_LAST) begin
         current_cutback_o <= 1'b1; // R12
      end
   end
endmodule

//--- tb/closed_loop_step_sequencer_chk.sv
// port assertions of the step sequencer
`timescale 1ns/1ps
`include "step_seq_params.svh"
module closed_loop_step_sequencer_chk #(parameter int DEV_W = 16) (
   input logic core_clk_i,
   input logic rst_b_i,
   input logic pulse_mode_i,
   input logic step_cw_i,
   input logic ccw_dir_i,
   input logic rotor_step_i,
   input logic rotor_dir_cw_i,
   input logic [3:0] filter_sel_i,
   input logic [3:0] excite_phase_o,
   input logic excitation_phase_zero_output,
   input logic closed_loop_o,
   input logic current_cutback_o,
   input logic signed [DEV_W-1:0] deviation_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);
   logic [3:0] prev_q;
   logic       pcl_q;
   // last phase and mode; tim_zero_a and one_step_a skip closed loop and the cycle after a mode change
   always_ff @(posedge core_clk_i) begin
      prev_q <= excite_phase_o;
      pcl_q  <= closed_loop_o;
   end
   wire open2 = !closed_loop_o && !pcl_q;
   wire [3:0] up = (prev_q == `SEQ_LAST) ? `SEQ_ZERO : prev_q + 4'h1;
   wire [3:0] dn = (prev_q == `SEQ_ZERO) ? `SEQ_LAST : prev_q - 4'h1;
   wire big = deviation_o >= `DEV_THRESH || deviation_o <= -`DEV_THRESH;
   // filter 0 lets every pending step land within eight quiet cycles
   wire quiet = !step_cw_i && !rotor_step_i && !(pulse_mode_i && ccw_dir_i)
      && filter_sel_i == 4'h0;
   sequence big3_s; big[*3]; endsequence
   sequence small3_s; (!big)[*3]; endsequence
   tim_zero_a: assert property (open2 |->
      excitation_phase_zero_output == (excite_phase_o == `SEQ_ZERO)) else $error("bad tim");
   one_step_a: assert property (open2 && excite_phase_o != prev_q |->
      excite_phase_o == up || excite_phase_o == dn) else $error("bad step");
   phase_range_a: assert property (excite_phase_o <= `SEQ_LAST) else $error("bad phase");
   closed_on_a: assert property (big3_s |-> closed_loop_o) else $error("not closed");
   open_on_a: assert property (small3_s |-> !closed_loop_o) else $error("not open");
   cut_clear_a: assert property ($rose(step_cw_i) |-> ##[1:20] !current_cutback_o)
      else $error("cutback stays");
   quiet_hold_a: assert property (quiet[*8] |-> $stable(deviation_o)
      && $stable(excite_phase_o)) else $error("moved idle");
   reset_val_a: assert property (disable iff (1'b0) !rst_b_i |=> excite_phase_o == 4'h0
      && excitation_phase_zero_output && !closed_loop_o && deviation_o == '0)
      else $error("bad reset");
endmodule
bind closed_loop_step_sequencer closed_loop_step_sequencer_chk #(.DEV_W(DEV_W)) u_chk (.*);

//--- tb/step_ctrl_model.sv
// positioning controller that issues step pulses
`timescale 1ns/1ps
module step_ctrl_model (
   input  wire logic core_clk_i,
   input  wire logic mode_i,
   input  wire logic req_i,
   input  wire logic ccw_i,
   input  wire logic home_i,
   input  wire logic tim_i,
   output logic      step_cw_o = 1'b0,
   output logic      ccw_dir_o = 1'b0
);
   logic [1:0] gap_q = 2'h0;
   // two idle cycles after each pulse so the stop sees a settled timing output
   always @(negedge core_clk_i) begin
      if (gap_q != 2'h0) begin
         gap_q     <= gap_q - 2'h1;
         step_cw_o <= 1'b0;
         ccw_dir_o <= ccw_dir_o && !mode_i;
      end else if (req_i && !(home_i && tim_i)) begin
         gap_q     <= 2'h2;
         step_cw_o <= !(mode_i && ccw_i);
         ccw_dir_o <= ccw_i;
      end
   end
endmodule

//--- tb/tb_closed_loop_step_sequencer.sv
// self-checking bench of the step sequencer
`timescale 1ns/1ps
module tb_closed_loop_step_sequencer;
   logic core_clk_i = 1'b0, rst_b_i = 1'b0, pulse_mode_i = 1'b0, step_cw_i, ccw_dir_i;
   logic rotor_step_i = 1'b0, rotor_dir_cw_i = 1'b1, req = 1'b0, ccw = 1'b0, home = 1'b0;
   logic lone = 1'b0, ccw_seen = 1'b0;
   logic [3:0] filter_sel_i = 4'h0, excite_phase_o;
   logic excitation_phase_zero_output, closed_loop_o, current_cutback_o;
   logic signed [15:0] deviation_o;
   int n_errors = 0, num_checks = 0;
   always #12.5 core_clk_i = !core_clk_i;
   closed_loop_step_sequencer #(.IDLE_CYCLES(50)) u_dut (.*);
   step_ctrl_model u_ctrl (.core_clk_i(core_clk_i), .mode_i(pulse_mode_i), .req_i(req),
      .ccw_i(ccw), .home_i(home), .tim_i(excitation_phase_zero_output),
      .step_cw_o(step_cw_i), .ccw_dir_o(ccw_dir_i));
   // rotor sensor trails every commanded pulse by a cycle; lone adds a cw step
   always @(negedge core_clk_i) begin
      ccw_seen       <= ccw_dir_i;
      rotor_step_i   <= lone || step_cw_i || (pulse_mode_i && ccw_dir_i && !ccw_seen);
      rotor_dir_cw_i <= lone || (pulse_mode_i ? step_cw_i : !ccw_dir_i);
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test;
      if (n_errors == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk_i);
   endtask
   // req moves on rising edges, away from the model's falling-edge sampling
   task automatic pulse(input logic c);
      @(posedge core_clk_i) ccw = c;
      req = 1'b1;
      @(posedge core_clk_i) req = 1'b0;
   endtask
   task automatic t_seq;
      for (int i = 1; i <= 10; i++) begin
         pulse(1'b0);
         cyc(4);
         check(excite_phase_o, i % 10);
         check(excitation_phase_zero_output, i == 10);
      end
      pulse(1'b1);
      cyc(4);
      check(excite_phase_o, 4'h9);
      pulse_mode_i = 1'b1;
      pulse(1'b0);
      cyc(4);
      check(excite_phase_o, 4'h0);
      pulse(1'b1);
      cyc(4);
      check(excite_phase_o, 4'h9);
   endtask
   // longest filter: output must wait exactly sel+2 cycles
   task automatic t_filter;
      filter_sel_i = 4'hF;
      pulse(1'b0);
      cyc(17);
      check(excite_phase_o, 4'h9);
      cyc(1);
      check(excite_phase_o, 4'h0);
      filter_sel_i = 4'h0;
      cyc(4);
   endtask
   task automatic t_home_cut;
      pulse_mode_i = 1'b0;
      @(posedge core_clk_i) req = 1'b1;
      cyc(7);
      @(posedge core_clk_i) home = 1'b1;
      cyc(90);
      check(excite_phase_o, 4'h0);
      check(current_cutback_o, 1'b1);
      @(posedge core_clk_i) req = 1'b0;
      home = 1'b0;
      pulse(1'b0);
      cyc(4);
      check(current_cutback_o, 1'b0);
   endtask
   // rotor runs ahead with no command: deviation falls one per sensor step,
   // closed loop from the third step on, where the rotor state drives the phase
   task automatic t_loop;
      rst_b_i = 1'b0;
      cyc(2);
      rst_b_i = 1'b1;
      for (int i = 1; i <= 5; i++) begin
         @(posedge core_clk_i) lone = 1'b1;
         @(posedge core_clk_i) lone = 1'b0;
         cyc(6);
         check(deviation_o, -i);
         check(closed_loop_o, i >= 3);
         check(excite_phase_o, (i >= 3) ? i : 0);
      end
   endtask
   initial begin
      cyc(20);
      rst_b_i = 1'b1;
      cyc(1);
      check({excite_phase_o, excitation_phase_zero_output, current_cutback_o}, 6'h02);
      t_seq();
      t_filter();
      t_home_cut();
      t_loop();
      end_of_test();
   end
   // hang guard, well past the few hundred cycles of the run
   initial begin
      #200us;
      n_errors++;
      end_of_test();
   end
endmodule
